// ===== include/radio_ctrl_pkg.sv
// constants shared by the reset, clock-out and synthesizer control logic
package radio_ctrl_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [5:0] IDX_GENERAL = 6'h00;
	localparam logic [5:0] IDX_DEVIATION = 6'h02;
	localparam logic [5:0] IDX_DIVIDER_BASE = 6'h06;
	localparam logic [5:0] IDX_SYNTH_IRQ = 6'h0e;
	localparam logic [5:0] IDX_CLOCK_OUT = 6'h1b;
	localparam logic [5:0] IDX_MOD_CTRL = 6'h20;
	localparam int NUM_DIVIDERS = 6;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_GENERAL = 8'h28;
	localparam logic [7:0] RST_DEVIATION = 8'h03;
	localparam logic [7:0] RST_SYNTH_IRQ = 8'h01;
	localparam logic [7:0] RST_CLOCK_OUT = 8'hbc;
	localparam logic [7:0] RST_MOD_CTRL = 8'h00;
	// entries r1, p1, s1, r2, p2, s2 from the low byte up
	localparam logic [47:0] RST_DIVIDERS = 48'h32_62_74_32_64_77;

	// ==========================================================
	// field positions
	localparam int GEN_MODE_LSB = 5;
	localparam int GEN_BAND_LSB = 3;
	localparam int GEN_TRIM_LSB = 1;
	localparam int GEN_SET_BIT = 0;
	localparam int CKO_EN_BIT = 7;
	localparam int CKO_DIV_LSB = 2;
	localparam int IRQ_FLAG_BIT = 1;
	localparam int IRQ_PIN_EN_BIT = 0;
	localparam int IRQ_RSVD_BIT = 3;
	localparam int MOD_OOK_BIT = 0;

	// ==========================================================
	// operating modes and synthesizer constants
	localparam logic [2:0] MODE_SLEEP = 3'h0;
	localparam logic [2:0] MODE_TX = 3'h4;
	localparam logic [15:0] SYNTH_P_MULT = 16'h004b;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int POR_TIME_NS = 8000;
	localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_POR = 3'b001,
		ST_MANUAL = 3'b010,
		ST_RUN = 3'b100
	} reset_state_t;

endpackage

// ===== include/synth_ctrl_if.sv
// signals between the control core, clock-out divider and synth calculator
`timescale 1ns/1ns
interface synth_ctrl_if;
	logic clk_enable;
	logic [4:0] clk_ratio;
	logic clk_out;
	logic [7:0] r_val;
	logic [7:0] p_val;
	logic [7:0] s_val;
	logic [7:0] fdev;
	logic ook_tx;
	logic [8:0] ref_div;
	logic [15:0] fb_count;
	logic [7:0] dev_offset;

	modport ctrl (
		output clk_enable, clk_ratio, r_val, p_val, s_val, fdev, ook_tx,
		input clk_out, ref_div, fb_count, dev_offset
	);
	modport clkgen (
		input clk_enable, clk_ratio,
		output clk_out
	);
	modport calc (
		input r_val, p_val, s_val, fdev, ook_tx,
		output ref_div, fb_count, dev_offset
	);
endinterface

// ===== hdl/ref_clock_divider.sv
// divider that makes the buffered reference clock output
`timescale 1ns/1ns
module ref_clock_divider
	import radio_ctrl_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control core
	synth_ctrl_if.clkgen link
);

	logic [4:0] cnt;
	logic clk_q;
	wire at_end = (cnt == link.clk_ratio);

	// ==========================================================
	// half period is ratio plus one reference cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 5'h00;
			clk_q <= 1'b0;
		end else if (!link.clk_enable) begin
			cnt <= 5'h00;
			clk_q <= 1'b0;
		end else if (at_end) begin // [R8]
			cnt <= 5'h00;
			clk_q <= ~clk_q;
		end else begin
			cnt <= cnt + 5'h01;
		end
	end

	assign link.clk_out = clk_q;

	// ==========================================================
	property p_ratio_toggle;
		@(posedge pclk) disable iff (!presetn)
		link.clk_enable && at_end ##1 link.clk_enable |-> clk_q != $past(clk_q);
	endproperty
	a_ratio_toggle: assert property (p_ratio_toggle) // [R8]
		else $error("clock out did not toggle at ratio end");

endmodule

// ===== hdl/synth_word_calc.sv
// divider-set to synthesizer word calculation
`timescale 1ns/1ns
module synth_word_calc
	import radio_ctrl_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control core
	synth_ctrl_if.calc link
);

	logic [8:0] ref_div;
	logic [15:0] fb_count;
	logic [7:0] dev_offset;
	wire [15:0] p_plus1 = {8'h00, link.p_val} + 16'h0001;
	wire [15:0] p_term = 16'(SYNTH_P_MULT * p_plus1);
	wire [15:0] next_fb = p_term + {8'h00, link.s_val};

	// ==========================================================
	// rf = 9/8 * fxtal / ref_div * fb_count, minus offset in ook tx
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_div <= 9'h000;
			fb_count <= 16'h0000;
			dev_offset <= 8'h00;
		end else begin
			ref_div <= {1'b0, link.r_val} + 9'h001; // [R18]
			fb_count <= next_fb; // [R18]
			dev_offset <= link.ook_tx ? link.fdev : 8'h00; // [R19]
		end
	end

	assign link.ref_div = ref_div;
	assign link.fb_count = fb_count;
	assign link.dev_offset = dev_offset;

	// ==========================================================
	property p_fb_formula;
		@(posedge pclk) disable iff (!presetn)
		presetn |=> fb_count ==
			16'(SYNTH_P_MULT * ({8'h00, $past(link.p_val)} + 16'h0001))
			+ {8'h00, $past(link.s_val)};
	endproperty
	a_fb_formula: assert property (p_fb_formula) // [R18]
		else $error("feedback count does not match divider set");

endmodule

// ===== hdl/radio_reset_clock_synth_ctrl.sv
// reset sequencing, clock output, lock status and synthesizer registers
// How it works
// [R1] host waits 10 ms after power-on reset; the host model waits WAIT_CYCLES pclk cycles after clock output activity
// [R2] host leaves reset pin floating during POR
// [R3] host pulses reset pin high 100 us; the host model drives it for PULSE_CYCLES pclk cycles
// [R4] host waits 5 ms after manual reset; the host model waits WAIT_CYCLES pclk cycles after clock output activity
// [R5] device drives reset pin during POR
// [R6] clock output activity signals device ready
// [R7] clock output enable is control bit 7
// [R8] clock output ratio from bits 6 to 2
// [R9] clock output enabled after power-up
// [R10] clock output stops in sleep mode
// [R11] lock flag sticky, cleared by writing one
// [R12] lock pin enable shows lock on pin
// [R13] host programs band select per band
// [R14] host steps oscillator trim up from zero
// [R15] set select picks one of two divider sets
// [R16] host keeps R in 64..169, S <= P
// [R17] host sets R near 119
// [R18] synth words follow nine-eighths formula
// [R19] ook transmit offsets by deviation
// [R20] lock event beats same-cycle clear
`timescale 1ns/1ns
module radio_reset_clock_synth_ctrl
	import radio_ctrl_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// manual reset pin, driven high while its output enable is low
	input wire logic manual_reset_pin_in,
	output logic manual_reset_pin_out,
	output logic manual_reset_pin_oe_n,
	// analog synthesizer side
	input wire logic pll_lock,
	output logic lock_indicator_pin,
	output logic [2:0] op_mode,
	output logic [1:0] band_select,
	output logic [1:0] oscillator_trim,
	output logic [8:0] synth_ref_div,
	output logic [15:0] synth_fb_count,
	output logic [7:0] synth_dev_offset,
	// clock output and status
	output logic buffered_ref_clock_out,
	output logic chip_ready
);

	// ==========================================================
	// sub-blocks
	synth_ctrl_if link ();

	ref_clock_divider u_clkdiv (
		.pclk(pclk),
		.presetn(presetn),
		.link(link.clkgen)
	);

	synth_word_calc u_calc (
		.pclk(pclk),
		.presetn(presetn),
		.link(link.calc)
	);

	// ==========================================================
	// reset sequencer
	reset_state_t state;
	reset_state_t next_state;
	logic [15:0] por_cnt;
	wire por_done = (por_cnt == 16'(POR_CYCLES - 1));
	wire chip_rst = (state != ST_RUN);

	always_comb begin
		next_state = state;
		case (state)
			ST_POR: begin
				if (por_done)
					next_state = ST_RUN;
			end
			ST_MANUAL: begin
				if (!manual_reset_pin_in)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				// own power-on drive still echoes on the pin for a cycle
				if (manual_reset_pin_in && manual_reset_pin_oe_n)
					next_state = ST_MANUAL;
			end
			default: next_state = ST_POR;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_POR;
			por_cnt <= 16'h0000;
		end else begin
			state <= next_state;
			if (state == ST_POR && !por_done)
				por_cnt <= por_cnt + 16'h0001;
		end
	end

	// ==========================================================
	// apb decode
	wire [5:0] idx = paddr[7:2];
	wire aligned = (paddr[1:0] == 2'b00);
	wire hit_general = aligned && (idx == IDX_GENERAL);
	wire hit_dev = aligned && (idx == IDX_DEVIATION);
	wire hit_irq = aligned && (idx == IDX_SYNTH_IRQ);
	wire hit_cko = aligned && (idx == IDX_CLOCK_OUT);
	wire hit_mod = aligned && (idx == IDX_MOD_CTRL);
	wire hit_div = aligned && (idx >= IDX_DIVIDER_BASE)
		&& (idx < IDX_DIVIDER_BASE + 6'(NUM_DIVIDERS));
	wire [2:0] div_sel = 3'(idx - IDX_DIVIDER_BASE);
	wire mapped = hit_general | hit_dev | hit_irq | hit_cko | hit_mod | hit_div;
	wire setup = psel && !penable;
	// writes during any reset phase are dropped, registers sit at defaults
	wire wr = psel && penable && pready && pwrite && !chip_rst;

	// ==========================================================
	// registers
	logic [7:0] general_config_reg;
	logic [7:0] deviation_reg;
	logic [7:0] synth_irq_config_reg;
	logic [7:0] clock_output_control_reg;
	logic [7:0] mod_ctrl_reg;
	logic [7:0] divider_reg [NUM_DIVIDERS];
	logic lock_q;

	wire lock_rise = pll_lock && !lock_q;
	wire flag_clr = wr && hit_irq && pwdata[IRQ_FLAG_BIT];
	wire synth_lock_flag = synth_irq_config_reg[IRQ_FLAG_BIT];
	wire lock_pin_enable = synth_irq_config_reg[IRQ_PIN_EN_BIT];
	wire next_flag = lock_rise | (synth_lock_flag & ~flag_clr); // [R11] [R20]
	wire [7:0] irq_keep = 8'hff & ~(8'h01 << IRQ_FLAG_BIT)
		& ~(8'h01 << IRQ_RSVD_BIT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lock_q <= 1'b0;
		else
			lock_q <= pll_lock;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			general_config_reg <= RST_GENERAL;
			deviation_reg <= RST_DEVIATION;
			clock_output_control_reg <= RST_CLOCK_OUT; // [R9]
			mod_ctrl_reg <= RST_MOD_CTRL;
		end else if (chip_rst) begin
			general_config_reg <= RST_GENERAL;
			deviation_reg <= RST_DEVIATION;
			clock_output_control_reg <= RST_CLOCK_OUT; // [R9]
			mod_ctrl_reg <= RST_MOD_CTRL;
		end else if (wr) begin
			if (hit_general)
				general_config_reg <= pwdata[7:0];
			if (hit_dev)
				deviation_reg <= pwdata[7:0];
			if (hit_cko)
				clock_output_control_reg <= {pwdata[7:2], 2'b00};
			if (hit_mod)
				mod_ctrl_reg <= {7'h00, pwdata[MOD_OOK_BIT]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			synth_irq_config_reg <= RST_SYNTH_IRQ;
		else if (chip_rst)
			synth_irq_config_reg <= RST_SYNTH_IRQ;
		else begin
			if (wr && hit_irq)
				synth_irq_config_reg <= pwdata[7:0] & irq_keep;
			synth_irq_config_reg[IRQ_FLAG_BIT] <= next_flag; // [R11]
		end
	end

	// one write strobe per divider entry
	genvar gi;
	generate
		for (gi = 0; gi < NUM_DIVIDERS; gi++) begin : g_div
			wire wr_this = wr && hit_div && (div_sel == 3'(gi));
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					divider_reg[gi] <= RST_DIVIDERS[gi*8 +: 8];
				else if (chip_rst)
					divider_reg[gi] <= RST_DIVIDERS[gi*8 +: 8];
				else if (wr_this)
					divider_reg[gi] <= pwdata[7:0];
			end
		end
	endgenerate

	// ==========================================================
	// read mux and apb answer, zero wait states
	wire [7:0] div_rd = hit_div ? divider_reg[div_sel] : 8'h00;
	wire [7:0] rd_byte = hit_general ? general_config_reg :
		hit_dev ? deviation_reg :
		hit_irq ? synth_irq_config_reg :
		hit_cko ? clock_output_control_reg :
		hit_mod ? mod_ctrl_reg : div_rd;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite)
				prdata <= {24'h00_0000, rd_byte};
		end
	end

	// ==========================================================
	// clock output and synthesizer steering
	wire [2:0] mode = general_config_reg[GEN_MODE_LSB +: 3];
	wire set_two = general_config_reg[GEN_SET_BIT];
	wire ckout_on = clock_output_control_reg[CKO_EN_BIT] && !chip_rst
		&& (mode != MODE_SLEEP); // [R7] [R10]
	wire [2:0] set_base = set_two ? 3'h3 : 3'h0;

	assign link.clk_enable = ckout_on; // [R7]
	assign link.clk_ratio = clock_output_control_reg[CKO_DIV_LSB +: 5]; // [R8]
	assign link.r_val = divider_reg[set_base]; // [R15]
	assign link.p_val = divider_reg[set_base + 3'h1]; // [R15]
	assign link.s_val = divider_reg[set_base + 3'h2]; // [R15]
	assign link.fdev = deviation_reg;
	assign link.ook_tx = mod_ctrl_reg[MOD_OOK_BIT] && (mode == MODE_TX); // [R19]

	// ==========================================================
	// registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			manual_reset_pin_out <= 1'b1;
			manual_reset_pin_oe_n <= 1'b0;
			lock_indicator_pin <= 1'b0;
			op_mode <= 3'h0;
			band_select <= 2'h0;
			oscillator_trim <= 2'h0;
			synth_ref_div <= 9'h000;
			synth_fb_count <= 16'h0000;
			synth_dev_offset <= 8'h00;
			buffered_ref_clock_out <= 1'b0;
			chip_ready <= 1'b0;
		end else begin
			manual_reset_pin_out <= 1'b1;
			manual_reset_pin_oe_n <= (state != ST_POR); // [R5]
			lock_indicator_pin <= lock_pin_enable && pll_lock; // [R12]
			op_mode <= mode;
			band_select <= general_config_reg[GEN_BAND_LSB +: 2];
			oscillator_trim <= general_config_reg[GEN_TRIM_LSB +: 2];
			synth_ref_div <= link.ref_div;
			synth_fb_count <= link.fb_count;
			synth_dev_offset <= link.dev_offset;
			buffered_ref_clock_out <= link.clk_out;
			chip_ready <= !chip_rst;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_por_drive;
		state == ST_POR |=> !manual_reset_pin_oe_n && manual_reset_pin_out;
	endproperty
	a_por_drive: assert property (p_por_drive) // [R5]
		else $error("reset pin not driven during power-on reset");

	property p_ckout_off;
		!ckout_on [*3] |=> !buffered_ref_clock_out;
	endproperty
	a_ckout_off: assert property (p_ckout_off) // [R7]
		else $error("clock output active while disabled");

	property p_ckout_poweron;
		state == ST_POR |-> clock_output_control_reg[CKO_EN_BIT];
	endproperty
	a_ckout_poweron: assert property (p_ckout_poweron) // [R9]
		else $error("clock output not enabled at power-up");

	property p_sleep_stop;
		(mode == MODE_SLEEP) [*3] |=> !buffered_ref_clock_out;
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) // [R10]
		else $error("clock output runs in sleep mode");

	property p_flag_set;
		lock_rise && !chip_rst |=> synth_lock_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) // [R11]
		else $error("lock flag not set on lock");

	property p_flag_sticky;
		synth_lock_flag && !flag_clr && !chip_rst |=> synth_lock_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) // [R11]
		else $error("lock flag dropped without a clear");

	property p_set_wins;
		lock_rise && flag_clr |=> synth_lock_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) // [R20]
		else $error("clear beat a same-cycle lock event");

	property p_lock_pin;
		!lock_pin_enable |=> !lock_indicator_pin;
	endproperty
	a_lock_pin: assert property (p_lock_pin) // [R12]
		else $error("lock pin driven while disabled");

	sequence s_set_stable;
		presetn && $stable(set_two) && $stable(link.r_val) [*3];
	endsequence
	property p_set_select;
		s_set_stable |-> synth_ref_div == {1'b0, $past(link.r_val, 2)} + 9'h001;
	endproperty
	a_set_select: assert property (p_set_select) // [R15]
		else $error("reference divider not from selected set");

	property p_ook_offset;
		link.ook_tx ##2 1'b1 |-> synth_dev_offset == $past(deviation_reg, 2);
	endproperty
	a_ook_offset: assert property (p_ook_offset) // [R19]
		else $error("ook offset does not follow deviation");

endmodule

// ===== test/host_mcu_model.sv
// host side model: manual reset pin driver and readiness tracking
`timescale 1ns/1ns
module host_mcu_model #(
	parameter int PULSE_CYCLES = 25,
	parameter int WAIT_CYCLES = 60
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench request
	input wire logic pulse_req,
	// reset pin and clock output of the device
	input wire logic pin_out,
	input wire logic pin_oe_n,
	input wire logic clk_out,
	output logic pin_in,
	// host status
	output logic host_ready
);
	// ==========================================================
	// pin resolution
	logic host_drive;
	logic clk_last;
	logic clk_seen;
	int cnt;
	// a weak pull-down keeps a released pin low
	assign pin_in = (!pin_oe_n & pin_out) | host_drive;
	// ==========================================================
	// pulse and wait sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_drive <= 1'b0;
			host_ready <= 1'b0;
			clk_last <= 1'b0;
			clk_seen <= 1'b0;
			cnt <= 0;
		end else begin
			clk_last <= clk_out;
			if (host_drive) begin
				cnt <= cnt + 1;
				if (cnt == PULSE_CYCLES - 1) begin
					host_drive <= 1'b0;
					cnt <= 0;
				end
			end else if (pulse_req && host_ready && pin_oe_n) begin
				host_drive <= 1'b1;
				host_ready <= 1'b0;
				clk_seen <= 1'b0;
				cnt <= 0;
			end else if (!host_ready) begin
				if (clk_out != clk_last && pin_oe_n) begin
					clk_seen <= 1'b1;
				end
				if (clk_seen) begin
					cnt <= cnt + 1;
				end
				if (clk_seen && cnt == WAIT_CYCLES) begin
					host_ready <= 1'b1;
					cnt <= 0;
				end
			end
		end
	end
	// the host keeps its own clock, so sleep costs it nothing
endmodule

// ===== test/testbench.sv
// self-checking bench for the reset, clock-out and synth control block
`timescale 1ns/1ns
module testbench;
	import radio_ctrl_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pll_lock, pulse_req;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, pin_in, pin_out, pin_oe_n, lock_pin;
	logic [2:0] op_mode;
	logic [1:0] band, trim;
	logic [8:0] ref_div;
	logic [15:0] fb_count;
	logic [7:0] dev_off;
	logic clk_out, chip_ready, host_ready;
	logic [31:0] rnd, q;
	logic e, any;
	int fails, comparisons, n;
	radio_reset_clock_synth_ctrl dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .manual_reset_pin_in(pin_in),
		.manual_reset_pin_out(pin_out), .manual_reset_pin_oe_n(pin_oe_n),
		.pll_lock(pll_lock), .lock_indicator_pin(lock_pin),
		.op_mode(op_mode), .band_select(band), .oscillator_trim(trim),
		.synth_ref_div(ref_div), .synth_fb_count(fb_count),
		.synth_dev_offset(dev_off), .buffered_ref_clock_out(clk_out),
		.chip_ready(chip_ready));
	host_mcu_model host (.pclk(pclk), .presetn(presetn),
		.pulse_req(pulse_req), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.clk_out(clk_out), .pin_in(pin_in), .host_ready(host_ready));
	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] exp_fb(input logic [7:0] p, s);
		return SYNTH_P_MULT * ({8'h00, p} + 16'h0001) + {8'h00, s};
	endfunction
	task automatic chk_word(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// bus cycles, entered just after a rising edge
	task automatic apb(input logic wr, input logic [5:0] idx,
		input logic [7:0] d);
		int t;
		t = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && t < 40) begin
			t++;
			@(posedge pclk);
		end
		if (t == 40) fails++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_ready();
		int t;
		t = 0;
		while (host_ready !== 1'b1 && t < 4000) begin
			t++;
			@(posedge pclk);
		end
		if (t == 4000) fails++;
	endtask
	task automatic half(output int n);
		logic v;
		int t;
		n = 0;
		t = 0;
		repeat (2) begin
			v = clk_out;
			while (clk_out === v && t < 300) begin
				@(posedge pclk);
				t++;
			end
		end
		v = clk_out;
		while (clk_out === v && n < 300) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic quiet();
		any = 1'b0;
		// let the last toggle drain through the output flop first
		repeat (3) @(posedge pclk);
		repeat (80) begin
			@(posedge pclk);
			any = any | clk_out;
		end
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	// ==========================================================
	// clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
	end
	initial begin
		#(60000 * CLK_PERIOD_NS);
		fails++;
		report_and_stop();
	end
	// ==========================================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, pll_lock, pulse_req} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		fails = 0;
		comparisons = 0;
		rnd = 32'hcc56;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_bit(pin_oe_n, 1'b0);
		apb(1'b1, IDX_GENERAL, 8'hff);
		wait_ready();
		chk_bit(chip_ready, 1'b1);
		chk_bit(pin_oe_n, 1'b1);
		apb(1'b0, IDX_GENERAL, 8'h00);
		chk_word(q, {24'h0, RST_GENERAL});
		apb(1'b0, IDX_DEVIATION, 8'h00);
		chk_word(q, {24'h0, RST_DEVIATION});
		apb(1'b0, IDX_SYNTH_IRQ, 8'h00);
		chk_word(q, {24'h0, RST_SYNTH_IRQ});
		apb(1'b0, IDX_CLOCK_OUT, 8'h00);
		chk_word(q, {24'h0, RST_CLOCK_OUT});
		apb(1'b0, IDX_MOD_CTRL, 8'h00);
		chk_word(q, {24'h0, RST_MOD_CTRL});
		for (int k = 0; k < NUM_DIVIDERS; k++) begin
			apb(1'b0, IDX_DIVIDER_BASE + 6'(k), 8'h00);
			chk_word(q, {24'h0, RST_DIVIDERS[8*k+:8]});
		end
		apb(1'b0, 6'h3f, 8'h00);
		chk_word({q[30:0], e}, 32'h1);
		done("reset_and_map");
		half(n);
		chk_word(n, 32'd16);
		repeat (3) begin
			rnd = lfsr(rnd);
			apb(1'b1, IDX_CLOCK_OUT, {1'b1, rnd[4:0], 2'b00});
			half(n);
			chk_word(n, {27'h0, rnd[4:0]} + 32'h1);
		end
		apb(1'b1, IDX_CLOCK_OUT, 8'h04);
		quiet();
		chk_bit(any, 1'b0);
		apb(1'b1, IDX_CLOCK_OUT, 8'h84);
		apb(1'b1, IDX_GENERAL, {MODE_SLEEP, 5'h00});
		quiet();
		chk_bit(any, 1'b0);
		apb(1'b1, IDX_GENERAL, RST_GENERAL);
		half(n);
		chk_word(n, 32'd2);
		done("clock_out");
		pll_lock <= 1'b1;
		repeat (3) @(posedge pclk);
		chk_bit(lock_pin, 1'b1);
		apb(1'b0, IDX_SYNTH_IRQ, 8'h00);
		chk_word(q, 32'h3);
		apb(1'b1, IDX_SYNTH_IRQ, 8'h0a);
		apb(1'b0, IDX_SYNTH_IRQ, 8'h00);
		chk_word(q, 32'h0);
		chk_bit(lock_pin, 1'b0);
		pll_lock <= 1'b0;
		@(posedge pclk);
		pll_lock <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, IDX_SYNTH_IRQ, 8'h00);
		chk_word(q, 32'h2);
		// lock edge lands on the very edge of a write-one clear
		pll_lock <= 1'b0;
		@(posedge pclk);
		fork
			apb(1'b1, IDX_SYNTH_IRQ, 8'h02);
			begin
				@(posedge pclk);
				pll_lock <= 1'b1;
			end
		join
		apb(1'b0, IDX_SYNTH_IRQ, 8'h00);
		chk_word(q, 32'h2);
		done("lock");
		for (int i = 0; i < 6; i++) begin
			logic [7:0] r, p, s;
			rnd = lfsr(rnd);
			r = (i == 0) ? 8'h77 : 8'h40 + 8'(rnd[15:0] % 106);
			p = rnd[23:16];
			s = 8'(rnd[31:24] % ({24'h0, p} + 32'h1));
			apb(1'b1, IDX_DIVIDER_BASE + 6'(3 * (i % 2)), r);
			apb(1'b1, IDX_DIVIDER_BASE + 6'(3 * (i % 2) + 1), p);
			apb(1'b1, IDX_DIVIDER_BASE + 6'(3 * (i % 2) + 2), s);
			apb(1'b1, IDX_GENERAL, {7'h14, 1'(i % 2)});
			repeat (3) @(posedge pclk);
			chk_word(ref_div, {23'h0, r} + 32'h1);
			chk_word(fb_count, exp_fb(p, s));
		end
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, IDX_GENERAL, {3'h1, 4'(i), 1'b0});
			// outputs are one flop behind the register
			@(posedge pclk);
			chk_word({op_mode, band, trim}, {3'h1, 4'(i)});
		end
		rnd = lfsr(rnd);
		apb(1'b1, IDX_DEVIATION, rnd[7:0]);
		apb(1'b1, IDX_MOD_CTRL, 8'h01);
		apb(1'b1, IDX_GENERAL, {MODE_TX, 5'h08});
		repeat (3) @(posedge pclk);
		chk_word(dev_off, rnd[7:0]);
		apb(1'b1, IDX_MOD_CTRL, 8'h00);
		repeat (3) @(posedge pclk);
		chk_word(dev_off, 32'h0);
		done("synth");
		apb(1'b1, IDX_GENERAL, 8'h3e);
		pulse_req <= 1'b1;
		@(posedge pclk);
		pulse_req <= 1'b0;
		repeat (4) @(posedge pclk);
		chk_bit(chip_ready, 1'b0);
		apb(1'b1, IDX_GENERAL, 8'hff);
		wait_ready();
		apb(1'b0, IDX_GENERAL, 8'h00);
		chk_word(q, {24'h0, RST_GENERAL});
		done("manual_reset");
		report_and_stop();
	end
endmodule
